// File: src/kml_keyboard_link.sv
`timescale 1ns/1ps
// Function
// - One down report per press, no auto-repeat, every change reported.
// - Next byte waits for acknowledge of previous, except hard reset.
// - Hard-reset code sent on power-on, user reset or protocol error.
// - After hard reset, any non hard-reset code resends hard reset.
// - Lamp states survive protocol resets; host sets them.
// - Scanning enabled only by ack_scan_only or ack_scan_and_mouse.
// - Key report: row byte then column byte, prefix down or up.
// - First report byte needs byte_ack, anything else is an error.
// - Second byte needs a final acknowledge, which sets the modes.
// - Final ack low bits: bit 0 scan enable, bit 1 mouse unsolicited.
// - Mouse report X then Y on request or when non-zero and enabled.
// - Counts copied to holding registers; counters restart from this cycle's step.
// - Mouse X needs byte_ack, Y a final ack, else error.
// - Key reports before mouse reports unless a counter hit a limit.
// - Scanning off ignores changes; held keys reported on resume.
// - Commands taken when idle or mid-report; hard reset restarts at once.
// - Replies wait for the exchange end; repeats give one reply.
// - Lamp command low three bits drive caps, num, scroll lamps.
// - Identity request answered with 10 and six-bit type code.
// - Echo request returns 1110 plus data; null command ignored.
// - Debounced mouse buttons reported as row 7 columns 0 to 2.
// - Quadrature phase changes count signed seven-bit up or down.
// - A counter at either limit freezes both until they are sent.
// - Restart clears mice, stops scan, keys up, echoes two acks.
module kml_keyboard_link #(
  parameter int unsigned P_DEBOUNCE_CYC = kml_pkg::DEBOUNCE_CYC,
  parameter logic [5:0]  P_KBD_TYPE     = 6'h00 // Arbitrary value
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_arst_n,
  input  wire logic [111:0]             i_key_raw,
  input  wire kml_pkg::kml_mouse_pins_s i_mouse,
  input  wire logic                     i_user_reset,
  input  wire logic                     i_rx_valid,
  input  wire logic [7:0]               i_rx_data,
  output logic                          o_rx_ready,
  output logic                          o_tx_valid,
  output logic [7:0]                    o_tx_data,
  input  wire logic                     i_tx_ready,
  output kml_pkg::kml_lamps_s           o_lamps,
  output logic                          o_scan_enabled,
  output logic                          o_mouse_enabled
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Position in the counting sequence 11, 10, 00, 01
  function automatic logic [1:0] quad_pos(input logic [1:0] ab);
    logic [1:0] p;
    p = 2'h0;
    unique case (ab)
      2'b11: p = 2'h0;
      2'b10: p = 2'h1;
      2'b00: p = 2'h2;
      2'b01: p = 2'h3;
    endcase
    return p;
  endfunction : quad_pos

  // Step of +1, -1 or 0 between two phase pairs
  function automatic logic [6:0] quad_step(input logic [1:0] old_ab,
                                           input logic [1:0] new_ab);
    logic [1:0] d;
    d = quad_pos(new_ab) - quad_pos(old_ab);
    if (d == 2'h1)
      return 7'h01;
    else if (d == 2'h3)
      return 7'h7F;
    return 7'h00;
  endfunction : quad_step

  // Counter at its positive or negative limit
  function automatic logic at_limit(input logic [6:0] c);
    return (c == kml_pkg::MOUSE_MAX) || (c == kml_pkg::MOUSE_MIN);
  endfunction : at_limit

  // Take the third stage once second and third agree
  function automatic logic [7:0] agree(input logic [7:0] s2,
                                       input logic [7:0] s3,
                                       input logic [7:0] old);
    return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & old);
  endfunction : agree

  // Final acknowledge code
  function automatic logic is_final(input logic [7:0] b);
    return (b[7:4] == kml_pkg::FINAL_ACK_HI) && (b[3:2] == 2'h0);
  endfunction : is_final

  kml_pkg::kml_st_s st;
  kml_pkg::kml_st_s next_st;

  logic         rx_fire;
  logic         pop;
  logic         push;
  logic [7:0]   push_data;
  logic         locked;
  logic [6:0]   mv_x;
  logic [6:0]   mv_y;
  logic [127:0] cur;
  logic         cur_bit;
  logic [3:0]   key_pre;

  // ----------------------------------------------------------------
  // Byte link handshakes
  // ----------------------------------------------------------------
  // Receive only while the buffer can take a reply
  assign o_rx_ready      = !st.tx_cnt[1];
  assign rx_fire         = i_rx_valid && o_rx_ready;
  assign o_tx_valid      = (st.tx_cnt != 2'h0);
  assign o_tx_data       = st.tx_mem[st.tx_rd];
  assign pop             = o_tx_valid && i_tx_ready;
  assign o_lamps         = st.lamps;
  assign o_scan_enabled  = st.scan_en;
  assign o_mouse_enabled = st.mouse_en;

  // Live key image, mouse buttons at row 7
  assign cur     = {13'h0000, st.btn, st.keys};
  assign cur_bit = cur[st.idx];
  assign key_pre = cur_bit ? kml_pkg::KEY_DOWN_CODE
                           : kml_pkg::KEY_UP_CODE;
  assign locked  = at_limit(st.cnt_x) || at_limit(st.cnt_y);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st   = st;
    push      = 1'b0;
    push_data = 8'h00;

    // Input synchronisers
    next_st.ks1  = i_key_raw;
    next_st.ks2  = st.ks1;
    next_st.ks3  = st.ks2;
    next_st.keys = (~(st.ks2 ^ st.ks3) & st.ks3)
                 | ((st.ks2 ^ st.ks3) & st.keys);
    next_st.as1  = {i_user_reset, i_mouse};
    next_st.as2  = st.as1;
    next_st.as3  = st.as2;
    next_st.aux  = agree(st.as2, st.as3, st.aux);

    // Button debounce on the agreed levels
    for (int i = 0; i < 3; i++) begin
      if (st.aux[4+i] == st.btn[i]) begin
        next_st.db_cnt[i] = 20'h0_0000;
      end else if (st.db_cnt[i] == 20'(P_DEBOUNCE_CYC - 1)) begin
        next_st.btn[i]    = st.aux[4+i];
        next_st.db_cnt[i] = 20'h0_0000;
      end else begin
        next_st.db_cnt[i] = st.db_cnt[i] + 20'h0_0001;
      end
    end

    // Quadrature counting, frozen at a limit
    // Pairs are ordered (phase a, phase b), so a goes to the high bit
    mv_x = locked ? 7'h00 : quad_step({st.aux[0], st.aux[1]},
                                      {next_st.aux[0], next_st.aux[1]});
    mv_y = locked ? 7'h00 : quad_step({st.aux[2], st.aux[3]},
                                      {next_st.aux[2], next_st.aux[3]});
    next_st.cnt_x = st.cnt_x + mv_x;
    next_st.cnt_y = st.cnt_y + mv_y;

    // Protocol
    if (rx_fire) begin
      if (i_rx_data == kml_pkg::HARD_RESET_CODE) begin
        // Restart at once from any state
        next_st.scan_en   = 1'b0;
        next_st.mouse_en  = 1'b0;
        next_st.flags     = 128'h0;
        next_st.cnt_x     = 7'h00;
        next_st.cnt_y     = 7'h00;
        next_st.id_pend   = 1'b0;
        next_st.echo_pend = 1'b0;
        next_st.mreq_pend = 1'b0;
        push              = 1'b1;
        push_data         = kml_pkg::HARD_RESET_CODE;
        next_st.state     = kml_pkg::ST_WAIT_RESET_ACK_ONE;
      end else begin
        unique case (st.state)
          kml_pkg::ST_SEND_HARD_RESET_CODE: begin
            next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
          end
          kml_pkg::ST_WAIT_HARD_RESET_CODE: begin
            next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
          end
          kml_pkg::ST_WAIT_RESET_ACK_ONE: begin
            if (i_rx_data == kml_pkg::RESET_ACK_ONE) begin
              push          = 1'b1;
              push_data     = kml_pkg::RESET_ACK_ONE;
              next_st.state = kml_pkg::ST_WAIT_RESET_ACK_TWO;
            end else begin
              next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
            end
          end
          kml_pkg::ST_WAIT_RESET_ACK_TWO: begin
            if (i_rx_data == kml_pkg::RESET_ACK_TWO) begin
              push          = 1'b1;
              push_data     = kml_pkg::RESET_ACK_TWO;
              next_st.state = kml_pkg::ST_WAIT_MODE;
            end else begin
              next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
            end
          end
          kml_pkg::ST_WAIT_MODE: begin
            if (is_final(i_rx_data)) begin
              next_st.scan_en  = i_rx_data[kml_pkg::MODE_SCAN_BIT];
              next_st.mouse_en = i_rx_data[kml_pkg::MODE_MOUSE_BIT];
              next_st.state    = kml_pkg::ST_IDLE;
            end else begin
              next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
            end
          end
          kml_pkg::ST_IDLE, kml_pkg::ST_WAIT_BACK,
          kml_pkg::ST_WAIT_FINAL: begin
            if (i_rx_data[7:3] == kml_pkg::LAMP_SET_HI) begin
              next_st.lamps = i_rx_data[2:0];
            end else if (i_rx_data == kml_pkg::NULL_COMMAND) begin
              next_st.state = st.state;
            end else if (i_rx_data == kml_pkg::ID_REQUEST) begin
              next_st.id_pend = 1'b1;
            end else if (i_rx_data == kml_pkg::MOUSE_POSITION_REQUEST) begin
              next_st.mreq_pend = 1'b1;
            end else if (i_rx_data[7:4] == kml_pkg::ECHO_REQUEST_HI) begin
              next_st.echo_pend = 1'b1;
              next_st.echo_data = i_rx_data[3:0];
            end else if (st.state == kml_pkg::ST_WAIT_BACK &&
                         i_rx_data == kml_pkg::BYTE_ACK) begin
              push          = 1'b1;
              push_data     = st.second;
              next_st.state = kml_pkg::ST_WAIT_FINAL;
            end else if (st.state == kml_pkg::ST_WAIT_FINAL &&
                         is_final(i_rx_data)) begin
              next_st.scan_en  = i_rx_data[kml_pkg::MODE_SCAN_BIT];
              next_st.mouse_en = i_rx_data[kml_pkg::MODE_MOUSE_BIT];
              next_st.state    = kml_pkg::ST_IDLE;
            end else begin
              next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
            end
          end
        endcase
      end
    end else if (next_st.aux[7] && !st.aux[7]) begin
      next_st.state = kml_pkg::ST_SEND_HARD_RESET_CODE;
    end else if (!st.tx_cnt[1]) begin
      if (st.state == kml_pkg::ST_SEND_HARD_RESET_CODE) begin
        push          = 1'b1;
        push_data     = kml_pkg::HARD_RESET_CODE;
        next_st.state = kml_pkg::ST_WAIT_HARD_RESET_CODE;
      end else if (st.state == kml_pkg::ST_IDLE) begin
        // Replies wait here until the exchange has ended
        if (st.id_pend) begin
          push            = 1'b1;
          push_data       = {kml_pkg::ID_REPLY_HI, P_KBD_TYPE};
          next_st.id_pend = 1'b0;
        end else if (st.echo_pend) begin
          push              = 1'b1;
          push_data         = {kml_pkg::ECHO_REPLY_HI, st.echo_data};
          next_st.echo_pend = 1'b0;
        end else if (locked && (st.mouse_en || st.mreq_pend)) begin
          push              = 1'b1;
          push_data         = {1'b0, st.cnt_x};
          next_st.second    = {1'b0, st.cnt_y};
          next_st.cnt_x     = mv_x;
          next_st.cnt_y     = mv_y;
          next_st.mreq_pend = 1'b0;
          next_st.state     = kml_pkg::ST_WAIT_BACK;
        end else if (st.scan_en && cur_bit != st.flags[st.idx]) begin
          push                  = 1'b1;
          push_data             = {key_pre, 1'b0, st.idx[6:4]};
          next_st.second        = {key_pre, st.idx[3:0]};
          next_st.flags[st.idx] = cur_bit;
          next_st.idx           = st.idx + 7'h01;
          next_st.state         = kml_pkg::ST_WAIT_BACK;
        end else if (st.mreq_pend ||
                     (st.mouse_en &&
                      (st.cnt_x != 7'h00 || st.cnt_y != 7'h00))) begin
          push              = 1'b1;
          push_data         = {1'b0, st.cnt_x};
          next_st.second    = {1'b0, st.cnt_y};
          next_st.cnt_x     = mv_x;
          next_st.cnt_y     = mv_y;
          next_st.mreq_pend = 1'b0;
          next_st.state     = kml_pkg::ST_WAIT_BACK;
        end else begin
          next_st.idx = st.idx + 7'h01;
        end
      end
    end

    // Two-entry transmit buffer
    if (push) begin
      next_st.tx_mem[st.tx_wr] = push_data;
      next_st.tx_wr            = !st.tx_wr;
    end
    if (pop) begin
      next_st.tx_rd = !st.tx_rd;
    end
    next_st.tx_cnt = st.tx_cnt + {1'b0, push} - {1'b0, pop};
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st       <= '0;
      st.state <= kml_pkg::ST_SEND_HARD_RESET_CODE;
      st.lamps <= kml_pkg::LAMPS_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule : kml_keyboard_link

// File: src/kml_pkg.sv
package kml_pkg;

  // ----------------------------------------------------------------
  // Link byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] HARD_RESET_CODE        = 8'hFF;
  localparam logic [7:0] RESET_ACK_ONE          = 8'hFE;
  localparam logic [7:0] RESET_ACK_TWO          = 8'hFD;
  localparam logic [7:0] ID_REQUEST             = 8'h20;
  localparam logic [7:0] NULL_COMMAND           = 8'h21;
  localparam logic [7:0] MOUSE_POSITION_REQUEST = 8'h22;
  localparam logic [7:0] BYTE_ACK               = 8'h3F;
  localparam logic [3:0] FINAL_ACK_HI           = 4'h3;
  localparam logic [3:0] ECHO_REQUEST_HI        = 4'h4;
  localparam logic [3:0] ECHO_REPLY_HI          = 4'hE;
  localparam logic [3:0] KEY_DOWN_CODE          = 4'hD - 4'h1;
  localparam logic [3:0] KEY_UP_CODE            = 4'hD;
  localparam logic [4:0] LAMP_SET_HI            = 5'h00;
  localparam logic [1:0] ID_REPLY_HI            = 2'h2;

  // ----------------------------------------------------------------
  // Field positions, limits, reset values
  // ----------------------------------------------------------------
  localparam int         MODE_SCAN_BIT  = 0;
  localparam int         MODE_MOUSE_BIT = 1;
  localparam int         KEY_BITS       = 112;
  localparam logic [6:0] MOUSE_MAX      = 7'h3F;
  localparam logic [6:0] MOUSE_MIN      = 7'h40;
  localparam logic [2:0] LAMPS_RST      = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  localparam int DEBOUNCE_US  = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_FREQ_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SEND_HARD_RESET_CODE, ST_WAIT_HARD_RESET_CODE, ST_WAIT_RESET_ACK_ONE, ST_WAIT_RESET_ACK_TWO,
    ST_WAIT_MODE, ST_IDLE, ST_WAIT_BACK, ST_WAIT_FINAL
  } kml_state_e;

  typedef struct packed {
    logic [2:0] btn;
    logic       y_b;
    logic       y_a;
    logic       x_b;
    logic       x_a;
  } kml_mouse_pins_s;

  typedef struct packed {
    logic scroll;
    logic num;
    logic caps;
  } kml_lamps_s;

  typedef struct packed {
    kml_state_e             state;
    logic [1:0][7:0]        tx_mem;
    logic                   tx_rd;
    logic                   tx_wr;
    logic [1:0]             tx_cnt;
    logic [KEY_BITS-1:0]    ks1;
    logic [KEY_BITS-1:0]    ks2;
    logic [KEY_BITS-1:0]    ks3;
    logic [KEY_BITS-1:0]    keys;
    logic [7:0]             as1;
    logic [7:0]             as2;
    logic [7:0]             as3;
    logic [7:0]             aux;
    logic [2:0]             btn;
    logic [2:0][19:0]       db_cnt;
    logic [127:0]           flags;
    logic [6:0]             idx;
    logic                   scan_en;
    logic                   mouse_en;
    logic                   id_pend;
    logic                   echo_pend;
    logic [3:0]             echo_data;
    logic                   mreq_pend;
    logic [7:0]             second;
    logic [6:0]             cnt_x;
    logic [6:0]             cnt_y;
    kml_lamps_s             lamps;
  } kml_st_s;

endpackage : kml_pkg

// File: tb/kml_host_model.sv
`timescale 1ns/1ps
module kml_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_stall,
  input  wire logic       i_kbd_valid,
  input  wire logic [7:0] i_kbd_data,
  output logic            o_kbd_ready,
  output logic            o_host_valid,
  output logic [7:0]      o_host_data,
  input  wire logic       i_host_ready
);
  // ----------------------------------------------------------------
  // Host receiver and sender
  // ----------------------------------------------------------------
  logic [7:0] rxq [$];
  // Receiver stalls on request
  assign o_kbd_ready = !i_stall;
  // Collect whole keyboard bytes
  always @(posedge i_clk_sys) begin
    if (i_kbd_valid && o_kbd_ready) begin
      rxq.push_back(i_kbd_data);
    end
  end
  initial begin
    o_host_valid = 1'b0;
    o_host_data  = 8'h5A;
  end
  // One host byte, held until taken
  task automatic send(input logic [7:0] b);
    @(posedge i_clk_sys);
    #1;
    o_host_valid = 1'b1;
    o_host_data  = b;
    while (!i_host_ready) begin
      @(posedge i_clk_sys);
      #1;
    end
    @(posedge i_clk_sys);
    #1;
    o_host_valid = 1'b0;
    o_host_data  = ~b; // Released line shows no stale value
  endtask : send
endmodule : kml_host_model

// File: tb/kml_keyboard_link_assertions.sv
`timescale 1ns/1ps
module kml_keyboard_link_assertions (
  input wire logic                i_clk_sys,
  input wire logic                i_arst_n,
  input wire logic                i_rx_valid,
  input wire logic [7:0]          i_rx_data,
  input wire logic                o_rx_ready,
  input wire logic                o_tx_valid,
  input wire logic [7:0]          o_tx_data,
  input wire logic                i_tx_ready,
  input wire kml_pkg::kml_lamps_s o_lamps,
  input wire logic                o_scan_enabled,
  input wire logic                o_mouse_enabled
);
  // ----------------------------------------------------------------
  // Link handshake and mode checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic acc;
  // Host byte taken this edge
  assign acc = i_rx_valid && o_rx_ready;

  AST_TX_VALID_HOLD: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid)
    else $error("tx byte withdrawn before taken");
  AST_TX_DATA_HOLD: assert property (
    o_tx_valid && !i_tx_ready |=> $stable(o_tx_data))
    else $error("tx byte changed before taken");
  AST_RX_REFUSE: assert property (
    !o_rx_ready |-> o_tx_valid)
    else $error("rx refused with empty buffer");
  AST_POWER_ON_HARD_RESET_CODE: assert property (
    $rose(i_arst_n) |-> ##[1:2]
      (o_tx_valid && o_tx_data == kml_pkg::HARD_RESET_CODE))
    else $error("no hard reset code after reset");
  AST_LAMP_CAUSE: assert property (
    !$stable(o_lamps) |-> $past(acc) && $past(i_rx_data[7:3]) == 5'h00
      && o_lamps == $past(i_rx_data[2:0]))
    else $error("lamps changed without lamp command");
  AST_RESTART_MODES: assert property (
    acc && i_rx_data == kml_pkg::HARD_RESET_CODE
      |=> !o_scan_enabled && !o_mouse_enabled)
    else $error("modes kept after restart");
  AST_SCAN_CAUSE: assert property (
    $rose(o_scan_enabled) |-> $past(acc)
      && ($past(i_rx_data) inside {8'h31, 8'h33}))
    else $error("scan enabled without scan ack");
  AST_MOUSE_CAUSE: assert property (
    $rose(o_mouse_enabled) |-> $past(acc)
      && ($past(i_rx_data) inside {8'h32, 8'h33}))
    else $error("mouse enabled without mouse ack");

  // Main scenarios reached
  COV_BYTE_ACK: cover property (acc && i_rx_data == 8'h3F);
  COV_SCAN_ON: cover property ($rose(o_scan_enabled));
  COV_FULL: cover property (!o_rx_ready);
endmodule : kml_keyboard_link_assertions

bind kml_keyboard_link kml_keyboard_link_assertions chk_u (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
  .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_lamps(o_lamps),
  .o_scan_enabled(o_scan_enabled), .o_mouse_enabled(o_mouse_enabled));

// File: tb/kml_keyboard_link_test.sv
`timescale 1ns/1ps
module kml_keyboard_link_test;
  localparam logic [5:0] KBD_TYPE = 6'h2A; // Arbitrary value
  logic                     i_clk_sys = 1'b0;
  logic                     i_arst_n  = 1'b0;
  logic [111:0]             key_raw   = '0;
  kml_pkg::kml_mouse_pins_s mouse     = 7'h0F;
  logic                     user_rst  = 1'b0;
  logic                     stall     = 1'b0;
  logic                     rx_valid, rx_ready, tx_valid, tx_ready;
  logic                     scan_en, mouse_en;
  logic [7:0]               rx_data, tx_data;
  kml_pkg::kml_lamps_s      lamps;
  int                       failures  = 0;
  int                       samples_checked = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  kml_keyboard_link #(.P_DEBOUNCE_CYC(4), .P_KBD_TYPE(KBD_TYPE)) dut_u (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_key_raw(key_raw),
    .i_mouse(mouse), .i_user_reset(user_rst), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_lamps(lamps),
    .o_scan_enabled(scan_en), .o_mouse_enabled(mouse_en));

  kml_host_model hm_u (
    .i_clk_sys(i_clk_sys), .i_stall(stall), .i_kbd_valid(tx_valid),
    .i_kbd_data(tx_data), .o_kbd_ready(tx_ready), .o_host_valid(rx_valid),
    .o_host_data(rx_data), .i_host_ready(rx_ready));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic get(input logic [7:0] exp);
    int n;
    n = 0;
    while (hm_u.rxq.size() == 0 && n < 600) begin
      tick(1);
      n++;
    end
    if (hm_u.rxq.size() != 0) chk(hm_u.rxq.pop_front(), exp);
    else chk(8'hxx, exp);
  endtask : get
  task automatic none;
    tick(300);
    chk(8'(hm_u.rxq.size()), 8'h00);
  endtask : none
  task automatic restart(input logic [7:0] mode);
    hm_u.send(8'hFF);
    get(8'hFF);
    hm_u.send(8'hFE);
    get(8'hFE);
    hm_u.send(8'hFD);
    get(8'hFD);
    hm_u.send(mode);
    tick(3);
    chk({7'h00, scan_en}, {7'h00, mode[0]});
    chk({7'h00, mouse_en}, {7'h00, mode[1]});
  endtask : restart
  task automatic report(input logic [3:0] pre, row, col);
    get({pre, row});
    hm_u.send(8'h3F);
    get({pre, col});
    hm_u.send(8'h31);
  endtask : report
  task automatic step(input int ax, input logic [1:0] ab);
    if (ax == 0) {mouse.x_a, mouse.x_b} = ab;
    else {mouse.y_a, mouse.y_b} = ab;
    tick(6);
  endtask : step

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] modes [4];
    modes = '{8'h33, 8'h32, 8'h30, 8'h31};
    get(8'hFF);
    hm_u.send(8'h30);
    get(8'hFF);
    foreach (modes[i]) restart(modes[i]);
    user_rst = 1'b1;
    tick(8);
    user_rst = 1'b0;
    get(8'hFF);
    restart(8'h31);
  endtask : t_reset
  task automatic t_key;
    key_raw[2*16+5] = 1'b1;
    get(8'hC2);
    hm_u.send(8'h05);
    hm_u.send(8'h3F);
    get(8'hC5);
    hm_u.send(8'h31);
    chk({5'h00, lamps}, 8'h05);
    none();
    key_raw[2*16+5] = 1'b0;
    report(4'hD, 4'h2, 4'h5);
    key_raw[6*16+15] = 1'b1;
    report(4'hC, 4'h6, 4'hF);
    key_raw[6*16+15] = 1'b0;
    report(4'hD, 4'h6, 4'hF);
  endtask : t_key
  task automatic t_err;
    mouse.btn[0] = 1'b1;
    get(8'hC7);
    hm_u.send(8'h31);
    get(8'hFF);
    hm_u.send(8'h22);
    get(8'hFF);
    restart(8'h31);
    report(4'hC, 4'h7, 4'h0);
    chk({5'h00, lamps}, 8'h05);
    mouse.btn[0] = 1'b0;
    report(4'hD, 4'h7, 4'h0);
  endtask : t_err
  task automatic t_cmds;
    stall = 1'b1;
    hm_u.send(8'h20);
    hm_u.send(8'h4A);
    tick(4);
    chk({7'h00, rx_ready}, 8'h00);
    stall = 1'b0;
    hm_u.send(8'h21);
    get({2'h2, KBD_TYPE});
    get(8'hEA);
    none();
  endtask : t_cmds
  task automatic t_mouse;
    logic [1:0] fwd [4];
    logic [1:0] rev [4];
    fwd = '{2'h2, 2'h0, 2'h1, 2'h3};
    rev = '{2'h1, 2'h0, 2'h2, 2'h3};
    repeat (3) foreach (fwd[i]) step(0, fwd[i]);
    foreach (rev[i]) step(1, rev[i]);
    hm_u.send(8'h22);
    get(8'h0C);
    hm_u.send(8'h3F);
    get(8'h7C);
    hm_u.send(8'h31);
    hm_u.send(8'h22);
    get(8'h00);
    hm_u.send(8'h3F);
    get(8'h00);
    hm_u.send(8'h32);
    foreach (fwd[i]) step(0, fwd[i]);
    get(8'h01);
    hm_u.send(8'h3F);
    get(8'h00);
    hm_u.send(8'h30);
  endtask : t_mouse

  task automatic stop_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    tick(20);
    i_arst_n = 1'b1;
    t_reset();
    t_key();
    t_err();
    t_cmds();
    t_mouse();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    failures++;
    stop_test();
  end
endmodule : kml_keyboard_link_test
